// file: common/gpio_drive_regs.svh
// register offsets, field positions, reset values and codes of the pin block
// assumes: included by bare name from design files, definitions only
//
// Operation
// R01 - drive register 0x52: pin8 code bits 6-4, pin7 code bits 2-0
// R02 - drive register 0x53: pin10 code upper field, pin9 lower, reset zero
// R03 - drive code zero drives pin low and high, no keeper
// R04 - drive code one drives low and high and enables the bus keeper
// R05 - manual output register 0x58: bit n-1 sets pin n level
// R06 - manual output register 0x59: bit1 pin10, bit0 pin9, bits 7-2 reserved
// R07 - read-only register 0x5a reports pins one to eight input levels
// R08 - register 0x5b reports pin10 in bit1, pin9 in bit0
// R09 - drive and manual output registers reset to zero
// R10 - drive codes two to seven act as code zero
`ifndef GPIO_DRIVE_REGS_SVH
`define GPIO_DRIVE_REGS_SVH

`define DRIVE_PINS_7_8_OFS      8'h52
`define DRIVE_PINS_9_10_OFS     8'h53
`define MANUAL_PINS_1_8_OFS     8'h58
`define MANUAL_PINS_9_10_OFS    8'h59
`define SAMPLED_PINS_1_8_OFS    8'h5a
`define SAMPLED_PINS_9_10_OFS   8'h5b

`define REG_RESET_VALUE         8'h00
`define DRIVE_FIELD_MASK        8'h77
`define PAIR_FIELD_MASK         8'h03
`define HI_CODE_MSB             6
`define HI_CODE_LSB             4
`define LO_CODE_MSB             2
`define LO_CODE_LSB             0

`define CODE_PLAIN              3'h0
`define CODE_KEEPER             3'h1

`define PIN_COUNT               10
`define FIRST_CODED_PIN         6

`endif

// file: common/gpio_pkg.sv
// types shared by the pin block
// assumes: compiled before the design files
`default_nettype none
package gpio_pkg;

   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic [9:0] level;
      logic [9:0] oe_n;
      logic [9:0] keeper;
   } pin_drive_t;

endpackage : gpio_pkg
`default_nettype wire

// file: hw/gpio_drive_and_manual_io.sv
// drive mode, manual output and sampled input logic for ten pins
// assumes: host control port decoded to byte requests on clock_i,
// pad cells turn level, enable and keeper into the pin wire
`timescale 1ns/10ps
`default_nettype none
`include "gpio_drive_regs.svh"

module gpio_drive_and_manual_io (
   // clock and reset
   input  wire logic              clock_i,
   input  wire logic              rst_n_i,
   // register port
   input  wire gpio_pkg::reg_req_t reg_req_i,
   output var  logic [7:0]        reg_rdata_o,
   output var  logic              reg_rvalid_o,
   // pin function select, high selects manual drive
   input  wire logic [9:0]        manual_sel_i,
   // pins
   input  wire logic [9:0]        pin_in_i,
   output var  logic [9:0]        pin_out_o,
   output var  logic [9:0]        pin_oe_n_o,
   output var  logic [9:0]        keeper_en_o
);

   logic [7:0]           drive_78;
   logic [7:0]           drive_910;
   logic [7:0]           manual_18;
   logic [7:0]           manual_910;
   logic [7:0]           next_drive_78;
   logic [7:0]           next_drive_910;
   logic [7:0]           next_manual_18;
   logic [7:0]           next_manual_910;
   logic [7:0]           rdata;
   logic [7:0]           next_rdata;
   logic                 rvalid;
   logic                 next_rvalid;
   logic [9:0]           pin_meta;
   logic [9:0]           pin_sync;
   logic [11:0]          codes;
   logic [9:0]           next_keeper;
   gpio_pkg::pin_drive_t drive;
   gpio_pkg::pin_drive_t next_drive;

   // register writes and reads
   always_comb begin
      next_drive_78   = drive_78;
      next_drive_910  = drive_910;
      next_manual_18  = manual_18;
      next_manual_910 = manual_910;
      if (reg_req_i.wr) begin
         case (reg_req_i.addr)
            `DRIVE_PINS_7_8_OFS: begin
               next_drive_78 = reg_req_i.wdata & `DRIVE_FIELD_MASK; // R01
            end
            `DRIVE_PINS_9_10_OFS: begin
               next_drive_910 = reg_req_i.wdata & `DRIVE_FIELD_MASK; // R02
            end
            `MANUAL_PINS_1_8_OFS: begin
               next_manual_18 = reg_req_i.wdata; // R05
            end
            `MANUAL_PINS_9_10_OFS: begin
               next_manual_910 = reg_req_i.wdata & `PAIR_FIELD_MASK; // R06
            end
            // sampled registers ignore writes
            default: begin
               next_manual_910 = manual_910; // R07
            end
         endcase
      end
      next_rvalid = reg_req_i.rd;
      next_rdata  = `REG_RESET_VALUE;
      if (reg_req_i.rd) begin
         case (reg_req_i.addr)
            `DRIVE_PINS_7_8_OFS:    next_rdata = drive_78;
            `DRIVE_PINS_9_10_OFS:   next_rdata = drive_910;
            `MANUAL_PINS_1_8_OFS:   next_rdata = manual_18;
            `MANUAL_PINS_9_10_OFS:  next_rdata = manual_910;
            `SAMPLED_PINS_1_8_OFS:  next_rdata = pin_sync[7:0]; // R07
            `SAMPLED_PINS_9_10_OFS: begin
               next_rdata = {6'h00, pin_sync[9:8]}; // R08
            end
            default:                next_rdata = `REG_RESET_VALUE;
         endcase
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         drive_78     <= `REG_RESET_VALUE; // R09
         drive_910    <= `REG_RESET_VALUE; // R09
         manual_18    <= `REG_RESET_VALUE; // R09
         manual_910   <= `REG_RESET_VALUE; // R09
         rdata        <= `REG_RESET_VALUE;
         rvalid       <= 1'b0;
      end else begin
         drive_78     <= next_drive_78;
         drive_910    <= next_drive_910;
         manual_18    <= next_manual_18;
         manual_910   <= next_manual_910;
         rdata        <= next_rdata;
         rvalid       <= next_rvalid;
      end
   end

   // two-flop input synchroniser
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         pin_meta <= 10'h000;
         pin_sync <= 10'h000;
      end else begin
         pin_meta <= pin_in_i;
         pin_sync <= pin_meta;
      end
   end

   // drive codes of pins seven to ten, highest pin first
   assign codes = {drive_910[`HI_CODE_MSB:`HI_CODE_LSB],
                   drive_910[`LO_CODE_MSB:`LO_CODE_LSB],
                   drive_78[`HI_CODE_MSB:`HI_CODE_LSB],
                   drive_78[`LO_CODE_MSB:`LO_CODE_LSB]};

   // keeper per pin, only code one enables it
   genvar gi;
   generate
      for (gi = 0; gi < `PIN_COUNT; gi = gi + 1) begin : g_pin
         if (gi >= `FIRST_CODED_PIN) begin : g_coded
            assign next_keeper[gi] =
               (codes[3*(gi-`FIRST_CODED_PIN) +: 3] == `CODE_KEEPER); // R04 R10
         end else begin : g_plain
            assign next_keeper[gi] = 1'b0; // R03
         end
      end
   endgenerate

   // pin drive, manual level in push-pull when selected
   always_comb begin
      next_drive.level  = {manual_910[1:0], manual_18}; // R05 R06
      next_drive.oe_n   = ~manual_sel_i; // R03
      next_drive.keeper = next_keeper;
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         drive.level  <= 10'h000;
         drive.oe_n   <= 10'h3ff;
         drive.keeper <= 10'h000;
      end else begin
         drive <= next_drive;
      end
   end

   assign pin_out_o    = drive.level;
   assign pin_oe_n_o   = drive.oe_n;
   assign keeper_en_o  = drive.keeper;
   assign reg_rdata_o  = rdata;
   assign reg_rvalid_o = rvalid;

   // checks
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   logic wr_d78;
   logic wr_d910;
   assign wr_d78  = reg_req_i.wr && reg_req_i.addr == `DRIVE_PINS_7_8_OFS;
   assign wr_d910 = reg_req_i.wr && reg_req_i.addr == `DRIVE_PINS_9_10_OFS;

   a_drive78_fields: assert property ( // R01
      wr_d78 |=> drive_78 == ($past(reg_req_i.wdata) & 8'h77))
      else $error("pin 7/8 drive register field mismatch");

   a_drive910_fields: assert property ( // R02
      wr_d910 |=> drive_910 == ($past(reg_req_i.wdata) & 8'h77))
      else $error("pin 9/10 drive register field mismatch");

   a_plain_no_keeper: assert property ( // R03
      wr_d78 && reg_req_i.wdata[2:0] == 3'h0 && !reg_req_i.wdata[6]
      && !reg_req_i.wdata[5] && !reg_req_i.wdata[4]
      |=> ##1 keeper_en_o[7:6] == 2'b00)
      else $error("keeper on for drive code zero");

   a_keeper_on_one: assert property ( // R04
      wr_d910 && reg_req_i.wdata[6:4] == 3'h1 |=> ##1 keeper_en_o[9])
      else $error("keeper off for drive code one");

   a_manual_low8: assert property ( // R05
      reg_req_i.wr && reg_req_i.addr == 8'h58
      |=> ##1 pin_out_o[7:0] == $past(reg_req_i.wdata, 2))
      else $error("manual level of pins one to eight wrong");

   a_manual_high2: assert property ( // R06
      reg_req_i.wr && reg_req_i.addr == 8'h59
      |=> manual_910[7:2] == 6'h00 ##1
          pin_out_o[9:8] == $past(reg_req_i.wdata[1:0], 2))
      else $error("manual level of pins nine and ten wrong");

   a_sampled_low8: assert property ( // R07
      reg_req_i.rd && reg_req_i.addr == 8'h5a
      |=> reg_rvalid_o && reg_rdata_o == $past(pin_sync[7:0]))
      else $error("sampled read of pins one to eight wrong");

   a_sampled_ro: assert property ( // R07
      reg_req_i.wr && (reg_req_i.addr == 8'h5a || reg_req_i.addr == 8'h5b)
      |=> $stable(manual_18) && $stable(manual_910)
          && $stable(drive_78) && $stable(drive_910))
      else $error("write to sampled register changed state");

   a_sampled_high2: assert property ( // R08
      reg_req_i.rd && reg_req_i.addr == 8'h5b
      |=> reg_rdata_o == {6'h00, $past(pin_sync[9:8])})
      else $error("sampled read of pins nine and ten wrong");

   a_reset_zero: assert property ( // R09
      $past(!rst_n_i) |-> drive_78 == 8'h00 && manual_18 == 8'h00
                          && drive_910 == 8'h00 && manual_910 == 8'h00)
      else $error("registers not zero after reset");

   a_reserved_code: assert property ( // R10
      wr_d78 && reg_req_i.wdata[2:1] != 2'b00 |=> ##1 !keeper_en_o[6])
      else $error("reserved drive code enabled keeper");

   // pin-level checks
   a_oe_follows_sel: assert property ( // R03
      $past(rst_n_i) |-> pin_oe_n_o == ~$past(manual_sel_i))
      else $error("output enable does not follow pin select");

   a_low_pins_plain: assert property ( // R03
      keeper_en_o[5:0] == 6'h00)
      else $error("keeper on for a pin without drive code");

   a_keeper_pin7: assert property ( // R04
      $past(rst_n_i)
      |-> keeper_en_o[6] == ($past(drive_78[2:0]) == `CODE_KEEPER))
      else $error("keeper of pin seven does not follow its code");

   a_keeper_pin8: assert property ( // R04
      $past(rst_n_i)
      |-> keeper_en_o[7] == ($past(drive_78[6:4]) == `CODE_KEEPER))
      else $error("keeper of pin eight does not follow its code");

   a_keeper_pin9: assert property ( // R04
      $past(rst_n_i)
      |-> keeper_en_o[8] == ($past(drive_910[2:0]) == `CODE_KEEPER))
      else $error("keeper of pin nine does not follow its code");

   a_keeper_pin10: assert property ( // R04
      $past(rst_n_i)
      |-> keeper_en_o[9] == ($past(drive_910[6:4]) == `CODE_KEEPER))
      else $error("keeper of pin ten does not follow its code");

   a_level_follows: assert property ( // R05
      $past(rst_n_i) |-> pin_out_o
         == {$past(manual_910[1:0]), $past(manual_18)})
      else $error("pin levels do not follow manual registers");

   a_sync_delay: assert property ( // R07
      $past(rst_n_i) && $past(rst_n_i, 2)
      |-> pin_sync == $past(pin_in_i, 2))
      else $error("synchronised pins do not lag inputs by two");

   a_reset_outputs: assert property ( // R09
      $past(!rst_n_i) |-> pin_out_o == 10'h000 && pin_oe_n_o == 10'h3ff
                          && keeper_en_o == 10'h000 && !reg_rvalid_o)
      else $error("outputs not at reset values after reset");

   // register port checks
   a_rvalid_pulse: assert property ( // R07
      $past(rst_n_i) |-> reg_rvalid_o == $past(reg_req_i.rd))
      else $error("read valid does not follow read strobe");

   a_rdata_idle: assert property ( // R07
      !reg_rvalid_o |-> reg_rdata_o == 8'h00)
      else $error("read data not zero outside a read");

   a_rdata_drive78: assert property ( // R01
      reg_req_i.rd && reg_req_i.addr == `DRIVE_PINS_7_8_OFS
      |=> reg_rdata_o == $past(drive_78))
      else $error("read of pin 7/8 drive register wrong");

   a_rdata_drive910: assert property ( // R02
      reg_req_i.rd && reg_req_i.addr == `DRIVE_PINS_9_10_OFS
      |=> reg_rdata_o == $past(drive_910))
      else $error("read of pin 9/10 drive register wrong");

   a_rdata_manual18: assert property ( // R05
      reg_req_i.rd && reg_req_i.addr == `MANUAL_PINS_1_8_OFS
      |=> reg_rdata_o == $past(manual_18))
      else $error("read of manual register for pins 1-8 wrong");

   a_rdata_manual910: assert property ( // R06
      reg_req_i.rd && reg_req_i.addr == `MANUAL_PINS_9_10_OFS
      |=> reg_rdata_o == $past(manual_910))
      else $error("read of manual register for pins 9-10 wrong");

   a_reserved_zero: assert property ( // R01
      drive_78[7] == 1'b0 && drive_78[3] == 1'b0
      && drive_910[7] == 1'b0 && drive_910[3] == 1'b0
      && manual_910[7:2] == 6'h00)
      else $error("reserved register bits hold a one");

   c_keeper_used: cover property (wr_d910 ##2 keeper_en_o[8]);
   c_manual_high: cover property (manual_sel_i[0] ##1 pin_out_o[0]);
   c_sample_read: cover property (
      reg_req_i.rd && reg_req_i.addr == 8'h5a ##1 reg_rdata_o != 8'h00);
   c_pin_release: cover property (!pin_oe_n_o[0] ##1 pin_oe_n_o[0]);
   c_code_reserved: cover property (
      wr_d78 && reg_req_i.wdata[2:0] == 3'h7 ##2 !keeper_en_o[6]);

endmodule : gpio_drive_and_manual_io
`default_nettype wire

// file: tb/gpio_drive_and_manual_io_tb.sv
// bench of the pin block: registers and pin levels
// assumes: pin_partner drives the pin wires, one 250 MHz clock
`timescale 1ns/10ps
`default_nettype none
`include "gpio_drive_regs.svh"
module gpio_drive_and_manual_io_tb;
   logic               clock_i = 1'b0;
   logic               rst_n_i = 1'b0;
   gpio_pkg::reg_req_t reg_req_i = '0;
   logic [7:0]         reg_rdata_o;
   logic               reg_rvalid_o;
   logic [9:0]         manual_sel_i = '0;
   logic [9:0]         pin_in_i;
   logic [9:0]         pin_out_o;
   logic [9:0]         pin_oe_n_o;
   logic [9:0]         keeper_en_o;
   logic [9:0]         ext_level = '0;
   logic [9:0]         ext_drive = '0;
   int                 failures = 0;
   int                 compares = 0;
   always #2 clock_i = ~clock_i;
   gpio_drive_and_manual_io gpio_drive_and_manual_io_i (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .reg_req_i(reg_req_i),
      .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
      .manual_sel_i(manual_sel_i), .pin_in_i(pin_in_i),
      .pin_out_o(pin_out_o), .pin_oe_n_o(pin_oe_n_o),
      .keeper_en_o(keeper_en_o));
   pin_partner pin_partner_i (
      .clock_i(clock_i), .level_i(pin_out_o), .oe_n_i(pin_oe_n_o),
      .keeper_i(keeper_en_o), .ext_level_i(ext_level),
      .ext_drive_i(ext_drive), .pin_o(pin_in_i));
   task automatic summarize();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : summarize
   task automatic check(input string what, input logic [9:0] exp,
                        input logic [9:0] got);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      @(posedge clock_i);
      reg_req_i <= {1'b0, 1'b1, addr, data};
      @(posedge clock_i);
      reg_req_i <= '0;
      @(posedge clock_i);
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
      int n;
      @(posedge clock_i);
      reg_req_i <= {1'b1, 1'b0, addr, 8'h00};
      @(posedge clock_i);
      reg_req_i <= '0;
      #1;
      for (n = 0; n < 4 && reg_rvalid_o !== 1'b1; n++) begin
         @(posedge clock_i);
         #1;
      end
      if (n == 4) begin
         failures++;
         summarize();
      end else begin
         check($sformatf("read %h", addr), {2'h0, exp}, {2'h0, reg_rdata_o});
      end
   endtask : rd
   task automatic t_reset();
      check("pin_out_o", 10'h000, pin_out_o);
      check("keeper_en_o", 10'h000, keeper_en_o);
      rd(`DRIVE_PINS_7_8_OFS, 8'h00);
      rd(`DRIVE_PINS_9_10_OFS, 8'h00);
      rd(`MANUAL_PINS_1_8_OFS, 8'h00);
      rd(`MANUAL_PINS_9_10_OFS, 8'h00);
      rd(8'h70, 8'h00);
      $display("test reset done");
   endtask : t_reset
   task automatic t_drive();
      @(posedge clock_i);
      manual_sel_i <= 10'h3ff;
      wr(`DRIVE_PINS_7_8_OFS, 8'hff);
      rd(`DRIVE_PINS_7_8_OFS, 8'h77);
      check("keeper_en_o", 10'h000, keeper_en_o);
      wr(`DRIVE_PINS_7_8_OFS, 8'h11);
      check("keeper_en_o", 10'h0c0, keeper_en_o);
      check("pin_oe_n_o", 10'h000, pin_oe_n_o);
      wr(`DRIVE_PINS_9_10_OFS, 8'h12);
      rd(`DRIVE_PINS_9_10_OFS, 8'h12);
      check("keeper_en_o", 10'h2c0, keeper_en_o);
      wr(`DRIVE_PINS_7_8_OFS, 8'h01);
      check("keeper_en_o", 10'h240, keeper_en_o);
      wr(`DRIVE_PINS_9_10_OFS, 8'h01);
      check("keeper_en_o", 10'h140, keeper_en_o);
      wr(`DRIVE_PINS_7_8_OFS, 8'h00);
      check("keeper_en_o", 10'h100, keeper_en_o);
      $display("test drive done");
   endtask : t_drive
   task automatic t_manual();
      wr(`MANUAL_PINS_1_8_OFS, 8'ha5);
      wr(`MANUAL_PINS_9_10_OFS, 8'hff);
      rd(`MANUAL_PINS_9_10_OFS, 8'h03);
      check("pin_out_o", 10'h3a5, pin_out_o);
      wr(`MANUAL_PINS_9_10_OFS, 8'h02);
      check("pin_out_o", 10'h2a5, pin_out_o);
      $display("test manual done");
   endtask : t_manual
   task automatic t_inputs();
      @(posedge clock_i);
      manual_sel_i <= 10'h000;
      ext_drive <= 10'h3ff;
      ext_level <= 10'h2c3;
      repeat (4) @(posedge clock_i);
      rd(`SAMPLED_PINS_1_8_OFS, 8'hc3);
      check("pin_oe_n_o", 10'h3ff, pin_oe_n_o);
      rd(`SAMPLED_PINS_9_10_OFS, 8'h02);
      wr(`SAMPLED_PINS_1_8_OFS, 8'h00);
      rd(`SAMPLED_PINS_1_8_OFS, 8'hc3);
      @(posedge clock_i);
      ext_level <= 10'h13c;
      repeat (4) @(posedge clock_i);
      rd(`SAMPLED_PINS_1_8_OFS, 8'h3c);
      rd(`SAMPLED_PINS_9_10_OFS, 8'h01);
      $display("test inputs done");
   endtask : t_inputs
   initial begin
      repeat (6) @(posedge clock_i);
      rst_n_i <= 1'b1;
      #1;
      t_reset();
      t_drive();
      t_manual();
      t_inputs();
      summarize();
   end
endmodule : gpio_drive_and_manual_io_tb
`default_nettype wire

// file: tb/pin_partner.sv
// model of the circuitry on the ten pins
// assumes: bench gives an outside level and its drive enables
`timescale 1ns/10ps
`default_nettype none
module pin_partner (
   // clock
   input  wire logic       clock_i,
   // block side
   input  wire logic [9:0] level_i,
   input  wire logic [9:0] oe_n_i,
   input  wire logic [9:0] keeper_i,
   // outside drivers
   input  wire logic [9:0] ext_level_i,
   input  wire logic [9:0] ext_drive_i,
   // wire level
   output var  logic [9:0] pin_o
);
   logic [9:0] last = '0;
   always @(posedge clock_i) last <= pin_o;
   always_comb begin
      for (int n = 0; n < 10; n++) begin
         if (!oe_n_i[n]) pin_o[n] = level_i[n];
         else if (ext_drive_i[n]) pin_o[n] = ext_level_i[n];
         else if (keeper_i[n]) pin_o[n] = last[n];
         else pin_o[n] = ~last[n];
      end
   end
endmodule : pin_partner
`default_nettype wire
